// ==== tb/low_voltage_detect_control_bench.sv ====
// register and detection sequence tests of the detector control block
`timescale 1ns/10ps
`default_nettype none
module low_voltage_detect_control_bench;
    import lvd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, cmp_async, detector_enable, source_select, irq, err;
    logic [1:0] threshold_level_select;
    logic [15:0] vdd_mv = 16'h0bb8, ext_mv = 16'h0640;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    low_voltage_detect_control low_voltage_detect_control_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_async,
        .detector_enable, .source_select, .threshold_level_select, .irq);
    lvd_cmp_model lvd_cmp_model_i (.pclk, .en(detector_enable), .src(source_select),
        .lvl(threshold_level_select), .vdd_mv, .ext_mv, .out(cmp_async));
    initial forever #10 pclk = ~pclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
        chk({nm, " err"}, 32'(err), 32'h0);
    endtask
    task automatic irq_chk(input logic [31:0] en, input logic [31:0] e);
        apb(1'b1, IRQ_EN_ADDR, en);
        repeat (2) @(negedge pclk);
        chk("irq", 32'(irq), e);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("ctrl", 32'({detector_enable, source_select, threshold_level_select}), 32'h0);
        rd_chk("status", STATUS_ADDR, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, CTRL_ADDR, 32'(i << 1));
            @(negedge pclk);
            chk("src lvl", 32'({threshold_level_select, source_select}), 32'(i));
        end
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped rd", rd, 32'h0);
        $display("test registers done");
        // external input, top threshold; supply stays high so a wrong source shows
        apb(1'b1, CTRL_ADDR, 32'h0000000f);
        rd_chk("settling", CTRL_ADDR, 32'h0);
        repeat (SETTLE_CYCLES) @(posedge pclk);
        rd_chk("first read", CTRL_ADDR, 32'h0);
        rd_chk("second read", CTRL_ADDR, 32'h1);
        ext_mv <= 16'h05aa;
        repeat (4) @(posedge pclk);
        rd_chk("low read", CTRL_ADDR, 32'h0);
        rd_chk("events", STATUS_ADDR, 32'h3);
        irq_chk(32'h2, 32'h1);
        irq_chk(32'h0, 32'h0);
        apb(1'b1, CLEAR_ADDR, 32'h3);
        apb(1'b1, STATUS_ADDR, 32'h3);
        rd_chk("cleared", STATUS_ADDR, 32'h0);
        rd_chk("clear reg", CLEAR_ADDR, 32'h0);
        irq_chk(32'h3, 32'h0);
        apb(1'b1, CTRL_ADDR, 32'h0);
        @(negedge pclk);
        chk("enable off", 32'(detector_enable), 32'h0);
        $display("test detection done");
        // supply at its top threshold; sense input low so a wrong source shows
        ext_mv <= 16'h0000;
        apb(1'b1, CTRL_ADDR, 32'h0000000d);
        repeat (SETTLE_CYCLES + 2) @(posedge pclk);
        rd_chk("supply first", CTRL_ADDR, 32'h0);
        rd_chk("supply high", CTRL_ADDR, 32'h1);
        vdd_mv <= 16'h0b54;
        repeat (4) @(posedge pclk);
        rd_chk("supply low", CTRL_ADDR, 32'h0);
        apb(1'b1, CTRL_ADDR, 32'h0);
        $display("test supply done");
        finish_test();
    end
endmodule
`default_nettype wire

// ==== tb/lvd_cmp_model.sv ====
// comparator model with four thresholds for each sensed source
`timescale 1ns/10ps
`default_nettype none
module lvd_cmp_model (
    input wire logic pclk, // clock for the idle pattern
    input wire logic en, // comparator powered
    input wire logic src, // 1 selects the external sense input
    input wire logic [1:0] lvl, // threshold code
    input wire logic [15:0] vdd_mv, // supply in mV
    input wire logic [15:0] ext_mv, // sense input in mV
    output logic out // high while powered and at or above threshold
);
    logic idle_q = 1'b0;
    logic [15:0] thr;
    assign thr = src ? 16'h04b0 + 16'h0064 * lvl : 16'h0960 + 16'h00c8 * lvl;
    always @(posedge pclk) idle_q <= ~idle_q;
    // unpowered output wanders, so a result taken while off cannot look right
    assign out = en ? ((src ? ext_mv : vdd_mv) >= thr) : idle_q;
endmodule
`default_nettype wire

// ==== tb/lvd_props.sv ====
// apb and control field properties of the detector control block
`timescale 1ns/10ps
`default_nettype none
module lvd_props
    import lvd_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic cmp_async, // comparator
    input wire logic detector_enable, // enable out
    input wire logic source_select, // source out
    input wire logic [1:0] threshold_level_select, // level out
    input wire logic irq // interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ctrl_wr;
    logic ctrl_rd;
    logic mapped;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_ADDR;
    assign ctrl_rd = psel && penable && pready && !pwrite && paddr == CTRL_ADDR;
    assign mapped = paddr inside {CTRL_ADDR, STATUS_ADDR, CLEAR_ADDR, IRQ_EN_ADDR};
    sequence s_xfer; (psel && !penable) ##1 (psel && penable); endsequence
    property p_ready; s_xfer |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access cycle");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held too long");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error flag wrong for address");
    property p_en; ctrl_wr |=> detector_enable == $past(pwdata[EN_BIT]); endproperty
    a_en: assert property (p_en) else $error("enable not taken");
    property p_src; ctrl_wr |=> source_select == $past(pwdata[SRC_BIT]); endproperty
    a_src: assert property (p_src) else $error("source not taken");
    property p_lvl;
        ctrl_wr |=> threshold_level_select == $past(pwdata[LVL_MSB:LVL_LSB]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("level not taken");
    property p_hold;
        !ctrl_wr |=> $stable({detector_enable, source_select, threshold_level_select});
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without write");
    property p_settle;
        $rose(detector_enable) |-> (!ctrl_rd || prdata[RESULT_BIT] == 1'b0) [*8];
    endproperty
    a_settle: assert property (p_settle) else $error("result shown while settling");
endmodule
bind low_voltage_detect_control lvd_props lvd_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_async(cmp_async),
    .detector_enable(detector_enable), .source_select(source_select),
    .threshold_level_select(threshold_level_select), .irq(irq));
`default_nettype wire

// ==== verilog/low_voltage_detect_control.sv ====
// low voltage detector control: apb registers, read sequence, interrupt
`timescale 1ns/10ps
`default_nettype none
module low_voltage_detect_control
    import lvd_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic cmp_async, // comparator output, asynchronous
    output logic detector_enable, // powers the comparator
    output logic source_select, // 0 supply, 1 external_sense_input
    output logic [1:0] threshold_level_select, // threshold code
    output logic irq // level interrupt
);
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // a write lands only at the access edge, when ready is sampled high
    function automatic logic wr_at(input logic done, input logic wr,
        input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        wr_at = done && wr && hit(a, off);
    endfunction

    lvd_front_if fi ();

    lvd_front u_front (
        .pclk(pclk),
        .presetn(presetn),
        .cmp_async(cmp_async),
        .fi(fi)
    );

    logic enable_q;
    logic source_q;
    logic [1:0] level_q;
    detect_state_t state_q;
    detect_state_t state_d;
    logic [NUM_EVENTS-1:0] status_q;
    logic [NUM_EVENTS-1:0] irq_en_q;
    logic [NUM_EVENTS-1:0] event_d;
    logic settled_prev_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    logic setup_ph;
    logic access_done;
    logic wr_ctrl;
    logic rd_ctrl;
    logic wr_clear;
    logic wr_irq_en;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign access_done = psel && penable && pready_q;
    assign wr_ctrl = wr_at(access_done, pwrite, paddr, CTRL_ADDR);
    assign wr_clear = wr_at(access_done, pwrite, paddr, CLEAR_ADDR);
    assign wr_irq_en = wr_at(access_done, pwrite, paddr, IRQ_EN_ADDR);
    assign rd_ctrl = access_done && !pwrite && hit(paddr, CTRL_ADDR);
    // status writes are ignored without error; only unknown offsets raise one
    assign mapped = hit(paddr, CTRL_ADDR) || hit(paddr, STATUS_ADDR)
        || hit(paddr, CLEAR_ADDR) || hit(paddr, IRQ_EN_ADDR);
    // the settle timer sees the same registered enable as the comparator
    assign fi.enable = enable_q;

    // control fields drive the analog comparator directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= 1'b0;
            source_q <= SRC_SUPPLY;
            level_q <= LEVEL_RESET;
        end else if (wr_ctrl) begin
            enable_q <= pwdata[EN_BIT];
            source_q <= pwdata[SRC_BIT];
            level_q <= pwdata[LVL_MSB:LVL_LSB];
        end
    end

    // read sequence: settle, then one read to stabilise, then valid reads
    // a disable from any state returns to off, so the next enable arms again
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (enable_q) begin
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (fi.settled) begin
                    state_d = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (rd_ctrl) begin
                    state_d = ST_VALID;
                end
            end
            ST_VALID: begin
                state_d = ST_VALID;
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!enable_q) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // events: settle finished, and a valid read that showed low voltage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settled_prev_q <= 1'b0;
        end else begin
            settled_prev_q <= fi.settled;
        end
    end

    // the low event uses the value loaded for this read, so it matches what software saw
    always_comb begin
        event_d = EVENTS_RESET;
        event_d[EV_SETTLED] = fi.settled && !settled_prev_q;
        event_d[EV_LOW] = rd_ctrl && (state_q == ST_VALID) && !prdata_q[RESULT_BIT];
    end

    // an event in the same cycle as its clear wins
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_status
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status_q[i] <= 1'b0;
            end else if (event_d[i]) begin
                status_q[i] <= 1'b1;
            end else if (wr_clear && pwdata[i]) begin
                status_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= EVENTS_RESET;
        end else if (wr_irq_en) begin
            irq_en_q <= pwdata[NUM_EVENTS-1:0];
        end
    end

    // registered so irq comes from a flop; it lags the status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_en_q);
        end
    end

    // read data chosen in the setup cycle, held through the access cycle
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(paddr, CTRL_ADDR)) begin
            // before the stabilising read the bit carries no valid result
            if (state_q == ST_VALID) begin
                rdata_d[RESULT_BIT] = fi.cmp_level;
            end
        end else if (hit(paddr, STATUS_ADDR)) begin
            rdata_d[NUM_EVENTS-1:0] = status_q;
        end else if (hit(paddr, IRQ_EN_ADDR)) begin
            rdata_d[NUM_EVENTS-1:0] = irq_en_q;
        end
    end

    // one wait-free access: ready rises for the access cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !mapped;
            if (setup_ph && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign detector_enable = enable_q;
    assign source_select = source_q;
    assign threshold_level_select = level_q;
endmodule
`default_nettype wire

// ==== verilog/lvd_front.sv ====
// comparator synchroniser and settle timer
`timescale 1ns/10ps
`default_nettype none
module lvd_front
    import lvd_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic cmp_async, // raw comparator output, high when voltage above threshold
    lvd_front_if.front fi // link to control logic
);
    logic sync1_q;
    logic sync2_q;
    logic [CNT_W-1:0] cnt_q;
    logic settled_q;

    // first stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= cmp_async;
            sync2_q <= sync1_q;
        end
    end

    // a disable drops the count, so each enable waits the full time again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= CNT_ZERO;
            settled_q <= 1'b0;
        end else if (!fi.enable) begin
            cnt_q <= CNT_ZERO;
            settled_q <= 1'b0;
        end else if (!settled_q) begin
            if (cnt_q == SETTLE_LAST) begin
                settled_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + CNT_ONE;
            end
        end
    end

    assign fi.settled = settled_q;
    assign fi.cmp_level = sync2_q;
endmodule
`default_nettype wire

// ==== verilog/lvd_front_if.sv ====
// carries enable, settle status and synchronised comparator level
`timescale 1ns/10ps
`default_nettype none
interface lvd_front_if;
    logic enable;
    logic settled;
    logic cmp_level;
    modport ctrl (output enable, input settled, input cmp_level);
    modport front (input enable, output settled, output cmp_level);
endinterface
`default_nettype wire

// ==== verilog/lvd_pkg.sv ====
// shared constants of the low voltage detector control block
package lvd_pkg;
    localparam int unsigned ADDR_W = 12;
    // the printed offset is a register index; byte address is four times it
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h057;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h15c;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h160;
    localparam logic [ADDR_W-1:0] CLEAR_ADDR = 12'h164;
    localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 12'h168;

    localparam int unsigned EN_BIT = 0;
    localparam int unsigned SRC_BIT = 1;
    localparam int unsigned LVL_LSB = 2;
    localparam int unsigned LVL_MSB = 3;
    localparam int unsigned RESULT_BIT = 0;

    localparam logic [1:0] LEVEL_RESET = 2'h0;
    localparam logic SRC_SUPPLY = 1'b0;
    localparam logic SRC_EXTERNAL = 1'b1;

    localparam int unsigned NUM_EVENTS = 2;
    localparam int unsigned EV_SETTLED = 0;
    localparam int unsigned EV_LOW = 1;
    localparam logic [NUM_EVENTS-1:0] EVENTS_RESET = 2'h0;

    localparam int unsigned SETTLE_TIME_NS = 30000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 11;
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_SETTLE = 4'h2,
        ST_FIRST = 4'h4,
        ST_VALID = 4'h8
    } detect_state_t;
endpackage
